// [pkg/pif_cfg.svh]
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH
// How it works
// - A flag is set by its peripheral event whatever any enable bit says.
// - The two-wire receive and transmit flags are read-only and clear only on the clear-buffers pulse.
// - The serial peripheral summary flag is read-only and follows the OR of its unit's flag register.
// - The serial peripheral transmit and receive flags are read-only and ignore software writes.
// - The async unit summary flag is read-only and follows the OR of its interrupt register.
// - The async framing error flag is read-only and follows the OR of its error interrupt register.
// - The async transmit and receive flags are read-only and ignore software writes.
// - The two-wire error flag is read-only and follows the OR of its error register.
// - The two-wire summary flag is read-only and follows the OR of its interrupt register.
// - The first register holds hardware-set writable DMA channel 1 flags in bits 3 to 0.
// - The first register holds read-only two-wire and serial peripheral flags in bits 7 to 4.
// - The second register holds a writable timer 0 flag at bit 7 and read-only flags below it.
// - The third register holds writable flags in bits 7 to 5 and 3 to 0, with bit 4 reading zero.
// - A hardware-set writable flag stays one until software writes it to zero.
// - Every flag is zero after reset.

`define OFF_DMA_SPI 12'h000
`define OFF_UART_I2C_TMR 12'h004
`define OFF_TMR_WAVE 12'h008
`define OFF_IRQ_STATUS 12'h00C
`define OFF_IRQ_MASK 12'h010

`define FLAG_RESET 8'h00
`define HS_RESET 1'h0
`define IRQ_RESET 24'h000000

`define B2_TW_RX 7
`define B2_SP_SUM 6
`define B2_SP_TX 5
`define B2_SP_RX 4
`define B3_TMR0 7
`define B3_AS_SUM 6
`define B3_AS_ERR 5
`define B3_AS_TX 4
`define B3_AS_RX 3
`define B3_TW_ERR 2
`define B3_TW_SUM 1
`define B3_TW_TX 0
`define B4_UNIMP 4
`endif

// [pkg/pif_pkg.sv]
`default_nettype none
package pif_pkg;
  typedef logic [7:0] flag_byte_t;
  typedef logic [23:0] flag_word_t;
  typedef enum logic [5:0]
  {
    SEL_DMA_SPI = 6'h01,
    SEL_UART_I2C_TMR = 6'h02,
    SEL_TMR_WAVE = 6'h04,
    SEL_IRQ_STATUS = 6'h08,
    SEL_IRQ_MASK = 6'h10,
    SEL_NONE = 6'h20
  } reg_sel_t;
endpackage : pif_pkg
`default_nettype wire

// [core/hs_flag_bank.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pif_cfg.svh"
module hs_flag_bank
#(
  parameter int W = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] set_evt,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] flags_r
);
  logic [W-1:0] flags_nxt;

  // Set beats a same-cycle software clear so no event is lost
  assign flags_nxt = set_evt | (wr_en ? wr_data : flags_r);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          flags_r[i] <= `HS_RESET;
        else
          flags_r[i] <= flags_nxt[i];
      end
    end
  endgenerate
endmodule : hs_flag_bank
`default_nettype wire

// [core/peripheral_interrupt_flags.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pif_cfg.svh"
module peripheral_interrupt_flags
  import pif_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] dma_ch1_set,
  input wire logic timer_zero_set,
  input wire logic [6:0] waveform_timer_set,
  input wire logic twowire1_receive_set,
  input wire logic twowire1_transmit_set,
  input wire logic clear_buffers_bit,
  input wire logic [7:0] twowire_error_reg,
  input wire logic [7:0] twowire_int_reg,
  input wire logic [7:0] serial_periph_int_flags_reg,
  input wire logic serial_periph1_transmit_level,
  input wire logic serial_periph1_receive_level,
  input wire logic [7:0] async_unit_int_reg,
  input wire logic [7:0] async_error_int_reg,
  input wire logic async1_transmit_level,
  input wire logic async1_receive_level,
  output logic [23:0] req_flags,
  output logic irq
);

  function automatic reg_sel_t decode(input logic [11:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == `OFF_DMA_SPI)
      s = SEL_DMA_SPI;
    else if (a == `OFF_UART_I2C_TMR)
      s = SEL_UART_I2C_TMR;
    else if (a == `OFF_TMR_WAVE)
      s = SEL_TMR_WAVE;
    else if (a == `OFF_IRQ_STATUS)
      s = SEL_IRQ_STATUS;
    else if (a == `OFF_IRQ_MASK)
      s = SEL_IRQ_MASK;
    return s;
  endfunction : decode

  function automatic flag_word_t lanes(input flag_word_t d,
                                       input logic [3:0] st);
    flag_word_t m;
    m = {{8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return d & m;
  endfunction : lanes

  // Bus decode
  reg_sel_t sel;
  logic setup_ph;
  logic wr_fire;
  logic wr_dma_spi;
  logic wr_uart_i2c_tmr;
  logic wr_tmr_wave;
  logic wr_status;
  logic wr_mask;

  assign sel = decode(paddr);
  assign setup_ph = psel & ~penable;
  // Writes commit only at the edge where the access phase meets pready
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_dma_spi = wr_fire & (sel == SEL_DMA_SPI) & pstrb[0];
  assign wr_uart_i2c_tmr = wr_fire & (sel == SEL_UART_I2C_TMR) & pstrb[0];
  assign wr_tmr_wave = wr_fire & (sel == SEL_TMR_WAVE) & pstrb[0];
  assign wr_status = wr_fire & (sel == SEL_IRQ_STATUS);
  assign wr_mask = wr_fire & (sel == SEL_IRQ_MASK);

  // Hardware-set, software-writable flags
  logic [3:0] dma_ch1_flags;
  logic [0:0] timer_zero_flag;
  logic [6:0] waveform_timer_flags;
  logic [6:0] tw_wdata;

  // Only the writable positions reach the banks; the rest of a write drops
  assign tw_wdata = {pwdata[7:5], pwdata[3:0]};

  hs_flag_bank #(.W(4)) u_dma
  (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(dma_ch1_set),
    .wr_en(wr_dma_spi),
    .wr_data(pwdata[3:0]),
    .flags_r(dma_ch1_flags)
  );

  hs_flag_bank #(.W(1)) u_tmr0
  (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(timer_zero_set),
    .wr_en(wr_uart_i2c_tmr),
    .wr_data(pwdata[`B3_TMR0]),
    .flags_r(timer_zero_flag)
  );

  hs_flag_bank #(.W(7)) u_wave
  (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(waveform_timer_set),
    .wr_en(wr_tmr_wave),
    .wr_data(tw_wdata),
    .flags_r(waveform_timer_flags)
  );

  // Two-wire buffer flags: set by the unit, cleared only by clear-buffers
  logic twowire1_receive_flag_r;
  logic twowire1_transmit_flag_r;
  logic twowire1_receive_flag_nxt;
  logic twowire1_transmit_flag_nxt;

  assign twowire1_receive_flag_nxt = twowire1_receive_set |
    (twowire1_receive_flag_r & ~clear_buffers_bit);
  assign twowire1_transmit_flag_nxt = twowire1_transmit_set |
    (twowire1_transmit_flag_r & ~clear_buffers_bit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      twowire1_receive_flag_r <= `HS_RESET;
      twowire1_transmit_flag_r <= `HS_RESET;
    end
    else
    begin
      twowire1_receive_flag_r <= twowire1_receive_flag_nxt;
      twowire1_transmit_flag_r <= twowire1_transmit_flag_nxt;
    end
  end

  // Read-only flags mirror their source unit; the bus has no path in
  logic serial_periph1_summary_flag_r;
  logic serial_periph1_transmit_flag_r;
  logic serial_periph1_receive_flag_r;
  logic async1_summary_flag_r;
  logic async1_framing_error_flag_r;
  logic async1_transmit_flag_r;
  logic async1_receive_flag_r;
  logic twowire1_error_flag_r;
  logic twowire1_summary_flag_r;
  logic serial_periph1_summary_flag_nxt;
  logic serial_periph1_transmit_flag_nxt;
  logic serial_periph1_receive_flag_nxt;
  logic async1_summary_flag_nxt;
  logic async1_framing_error_flag_nxt;
  logic async1_transmit_flag_nxt;
  logic async1_receive_flag_nxt;
  logic twowire1_error_flag_nxt;
  logic twowire1_summary_flag_nxt;

  // A summary drops only once every bit of its source register is clear
  assign serial_periph1_summary_flag_nxt =
    |serial_periph_int_flags_reg;
  assign serial_periph1_transmit_flag_nxt =
    serial_periph1_transmit_level;
  assign serial_periph1_receive_flag_nxt =
    serial_periph1_receive_level;
  assign async1_summary_flag_nxt = |async_unit_int_reg;
  assign async1_framing_error_flag_nxt = |async_error_int_reg;
  assign async1_transmit_flag_nxt = async1_transmit_level;
  assign async1_receive_flag_nxt = async1_receive_level;
  assign twowire1_error_flag_nxt = |twowire_error_reg;
  assign twowire1_summary_flag_nxt = |twowire_int_reg;

  // Registered mirrors lag a cycle but cut the path from each unit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_periph1_summary_flag_r <= `HS_RESET;
      serial_periph1_transmit_flag_r <= `HS_RESET;
      serial_periph1_receive_flag_r <= `HS_RESET;
    end
    else
    begin
      serial_periph1_summary_flag_r <= serial_periph1_summary_flag_nxt;
      serial_periph1_transmit_flag_r <= serial_periph1_transmit_flag_nxt;
      serial_periph1_receive_flag_r <= serial_periph1_receive_flag_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async1_summary_flag_r <= `HS_RESET;
      async1_framing_error_flag_r <= `HS_RESET;
      async1_transmit_flag_r <= `HS_RESET;
      async1_receive_flag_r <= `HS_RESET;
    end
    else
    begin
      async1_summary_flag_r <= async1_summary_flag_nxt;
      async1_framing_error_flag_r <= async1_framing_error_flag_nxt;
      async1_transmit_flag_r <= async1_transmit_flag_nxt;
      async1_receive_flag_r <= async1_receive_flag_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      twowire1_error_flag_r <= `HS_RESET;
      twowire1_summary_flag_r <= `HS_RESET;
    end
    else
    begin
      twowire1_error_flag_r <= twowire1_error_flag_nxt;
      twowire1_summary_flag_r <= twowire1_summary_flag_nxt;
    end
  end

  // Register images
  flag_byte_t rd_dma_spi;
  flag_byte_t rd_uart_i2c_tmr;
  flag_byte_t rd_tmr_wave;

  assign rd_dma_spi[`B2_TW_RX] = twowire1_receive_flag_r;
  assign rd_dma_spi[`B2_SP_SUM] = serial_periph1_summary_flag_r;
  assign rd_dma_spi[`B2_SP_TX] = serial_periph1_transmit_flag_r;
  assign rd_dma_spi[`B2_SP_RX] = serial_periph1_receive_flag_r;
  assign rd_dma_spi[3:0] = dma_ch1_flags;

  assign rd_uart_i2c_tmr[`B3_TMR0] = timer_zero_flag[0];
  assign rd_uart_i2c_tmr[`B3_AS_SUM] = async1_summary_flag_r;
  assign rd_uart_i2c_tmr[`B3_AS_ERR] = async1_framing_error_flag_r;
  assign rd_uart_i2c_tmr[`B3_AS_TX] = async1_transmit_flag_r;
  assign rd_uart_i2c_tmr[`B3_AS_RX] = async1_receive_flag_r;
  assign rd_uart_i2c_tmr[`B3_TW_ERR] = twowire1_error_flag_r;
  assign rd_uart_i2c_tmr[`B3_TW_SUM] = twowire1_summary_flag_r;
  assign rd_uart_i2c_tmr[`B3_TW_TX] = twowire1_transmit_flag_r;

  assign rd_tmr_wave[7:5] = waveform_timer_flags[6:4];
  assign rd_tmr_wave[`B4_UNIMP] = 1'h0;
  assign rd_tmr_wave[3:0] = waveform_timer_flags[3:0];

  flag_word_t flags_all;

  assign flags_all = {rd_tmr_wave, rd_uart_i2c_tmr, rd_dma_spi};

  // Interrupt status: rising edge of any flag, sticky, write one to clear
  flag_word_t flags_prev_r;
  flag_word_t irq_status_r;
  flag_word_t irq_status_nxt;
  flag_word_t irq_mask_r;
  flag_word_t irq_mask_nxt;
  flag_word_t flag_rise;
  flag_word_t status_clr;

  assign flag_rise = flags_all & ~flags_prev_r;
  assign status_clr = wr_status ? lanes(pwdata[23:0], pstrb) : `IRQ_RESET;
  // A flag rising in the clearing cycle keeps its status bit
  assign irq_status_nxt = flag_rise | (irq_status_r & ~status_clr);
  assign irq_mask_nxt = wr_mask ?
    ((irq_mask_r & ~lanes({24{1'h1}}, pstrb)) | lanes(pwdata[23:0], pstrb)) :
    irq_mask_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_prev_r <= `IRQ_RESET;
      irq_status_r <= `IRQ_RESET;
      irq_mask_r <= `IRQ_RESET;
    end
    else
    begin
      flags_prev_r <= flags_all;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Registered irq adds one cycle of latency but keeps the pin glitch-free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'h0;
      req_flags <= `IRQ_RESET;
    end
    else
    begin
      irq <= |(irq_status_r & irq_mask_r);
      req_flags <= flags_all;
    end
  end

  // Read mux
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (sel)
      SEL_DMA_SPI:
        rd_mux = {24'h000000, rd_dma_spi};
      SEL_UART_I2C_TMR:
        rd_mux = {24'h000000, rd_uart_i2c_tmr};
      SEL_TMR_WAVE:
        rd_mux = {24'h000000, rd_tmr_wave};
      SEL_IRQ_STATUS:
        rd_mux = {8'h00, irq_status_r};
      SEL_IRQ_MASK:
        rd_mux = {8'h00, irq_mask_r};
      SEL_NONE:
        rd_mux = 32'h00000000;
    endcase
  end

  // Fixed one-wait-free answer: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph & (sel == SEL_NONE);
      if (setup_ph && !pwrite)
        prdata <= rd_mux;
    end
  end

endmodule : peripheral_interrupt_flags
`default_nettype wire

// [sim/periph_units.sv]
`timescale 1ns/100ps
`default_nettype none
module periph_units
(
  input wire logic pclk,
  output logic [58:0] src
);
  initial src = 59'h0;
  // Units are same-clock logic, so they change only right after an edge
  task automatic put(input logic [58:0] v);
    @(posedge pclk);
    src <= v;
  endtask : put
endmodule : periph_units
`default_nettype wire

// [sim/pif_props.sv]
`timescale 1ns/100ps
`default_nettype none
module pif_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic [3:0] dma_ch1_set,
  input wire logic twowire1_receive_set,
  input wire logic clear_buffers_bit,
  input wire logic [7:0] serial_periph_int_flags_reg,
  input wire logic [7:0] async_unit_int_reg,
  input wire logic [23:0] req_flags
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic wr0;
  wire logic sp_any;
  wire logic as_any;
  assign wr0 = psel & penable & pwrite & pready & (paddr == 12'h000);
  assign sp_any = |serial_periph_int_flags_reg;
  assign as_any = |async_unit_int_reg;
  reset_clear_a: assert property
    ($rose(presetn) |-> req_flags == 24'h000000)
    else $error("flags not zero after reset");
  dma_set_a: assert property
    (dma_ch1_set[3] |-> ##[1:2] req_flags[3])
    else $error("dma abort flag not set");
  hs_sticky_a: assert property
    ($fell(req_flags[3]) |-> $past(wr0) || $past(wr0, 2))
    else $error("writable flag dropped without a write");
  tw_hold_a: assert property
    ($rose(req_flags[7]) |->
      $past(twowire1_receive_set) || $past(twowire1_receive_set, 2))
    else $error("receive flag rose without its event");
  tw_clear_a: assert property
    (clear_buffers_bit && !twowire1_receive_set ##1 !twowire1_receive_set
      |-> ##1 !req_flags[7])
    else $error("receive flag survived buffer clear");
  sp_sum_a: assert property
    (sp_any [*3] |-> req_flags[6])
    else $error("serial summary not held");
  as_drop_a: assert property
    (!as_any [*3] |-> !req_flags[14])
    else $error("async summary not released");
  unimp_zero_a: assert property
    (req_flags[20] == 1'b0)
    else $error("unimplemented bit set");
endmodule : pif_props
bind peripheral_interrupt_flags pif_props u_props
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .dma_ch1_set(dma_ch1_set), .twowire1_receive_set(twowire1_receive_set),
  .clear_buffers_bit(clear_buffers_bit),
  .serial_periph_int_flags_reg(serial_periph_int_flags_reg),
  .async_unit_int_reg(async_unit_int_reg), .req_flags(req_flags)
);
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [23:0] req_flags;
  logic [58:0] src;
  int miscompares, total_checks;
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  periph_units u_per
  (
    .pclk(pclk),
    .src(src)
  );
  peripheral_interrupt_flags u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_ch1_set(src[3:0]), .timer_zero_set(src[4]),
    .waveform_timer_set(src[11:5]), .twowire1_receive_set(src[12]),
    .twowire1_transmit_set(src[13]), .clear_buffers_bit(src[14]),
    .twowire_error_reg(src[22:15]), .twowire_int_reg(src[30:23]),
    .serial_periph_int_flags_reg(src[38:31]),
    .serial_periph1_transmit_level(src[39]),
    .serial_periph1_receive_level(src[40]),
    .async_unit_int_reg(src[48:41]), .async_error_int_reg(src[56:49]),
    .async1_transmit_level(src[57]), .async1_receive_level(src[58]),
    .req_flags(req_flags), .irq(irq)
  );
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      $display("BAD %0t no pready", $time);
      complete_run;
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic irq_is(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq}, {31'h0, e});
    if (n >= 20)
      complete_run;
  endtask : irq_is
  task automatic s_reset;
    for (int i = 0; i < 5; i++)
      rd(12'(4 * i), 32'h0);
    chk({8'h00, req_flags}, 32'h0);
  endtask : s_reset
  task automatic s_hs;
    u_per.put(59'h0FFF);
    u_per.put(59'h0);
    rd(12'h000, 32'h0F);
    rd(12'h004, 32'h80);
    rd(12'h008, 32'hEF);
    chk({8'h00, req_flags}, 32'hEF800F);
    pstrb <= 4'h0;
    apb(1'b1, 12'h008, 32'h0);
    pstrb <= 4'hF;
    rd(12'h008, 32'hEF);
    apb(1'b1, 12'h008, 32'h0F);
    rd(12'h008, 32'h0F);
    apb(1'b1, 12'h008, 32'hFF);
    rd(12'h008, 32'hEF);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'h0);
  endtask : s_hs
  task automatic s_ro;
    // Every unit register full, then only its top bit left set
    u_per.put(59'h7FFFFFFFFFFB000);
    u_per.put(59'h70101C040400000);
    rd(12'h000, 32'hF0);
    rd(12'h004, 32'h7F);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    rd(12'h000, 32'hF0);
    rd(12'h004, 32'h7F);
    u_per.put(59'h0);
    rd(12'h000, 32'h80);
    rd(12'h004, 32'h01);
    u_per.put(59'h4000);
    u_per.put(59'h0);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
  endtask : s_ro
  task automatic s_irq;
    // Stale status must go before the mask opens, or irq fires at once
    apb(1'b1, 12'h00C, 32'hFFFFFFFF);
    rd(12'h00C, 32'h0);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    rd(12'h010, 32'h00FFFFFF);
    irq_is(1'b0);
    u_per.put(59'h10);
    u_per.put(59'h0);
    irq_is(1'b1);
    rd(12'h00C, 32'h8000);
    apb(1'b1, 12'h010, 32'h0);
    irq_is(1'b0);
    apb(1'b1, 12'h010, 32'hFFFFFF);
    irq_is(1'b1);
    apb(1'b1, 12'h00C, 32'h8000);
    irq_is(1'b0);
    rd(12'h004, 32'h80);
    apb(1'b1, 12'h004, 32'h0);
  endtask : s_irq
  task automatic s_bad;
    logic [11:0] a[3];
    a = '{12'h014, 12'h002, 12'hFFC};
    foreach (a[i])
    begin
      apb(1'b0, a[i], 32'h0);
      chk(q, 32'h0);
      chk({31'h0, err}, 32'h1);
    end
    apb(1'b1, 12'h014, 32'hFF);
    rd(12'h004, 32'h0);
  endtask : s_bad
  task automatic s_mid_reset;
    u_per.put(59'h0FFF);
    u_per.put(59'h0);
    rd(12'h008, 32'hEF);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    chk({8'h00, req_flags}, 32'h0);
    for (int i = 0; i < 5; i++)
      rd(12'(4 * i), 32'h0);
  endtask : s_mid_reset
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    miscompares = 0;
    total_checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_hs;
    s_ro;
    s_irq;
    s_bad;
    s_mid_reset;
    complete_run;
  end
endmodule : testbench
`default_nettype wire
